// *** rtl/alu_pkg.sv ***
package alu_pkg;

   localparam int DATA_W = 16;
   localparam int ACC_W  = 40;

   // ----------------------------------------------------------------
   // operation codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NOP,
      OP_ADD,
      OP_ADD_CARRY,
      OP_AND,
      OP_SHIFT_RIGHT,
      OP_ACC_ADD,
      OP_ADD_ACC
   } alu_op_e;

   // ----------------------------------------------------------------
   // operand source selection for the second operand
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_REG,
      SRC_TEN_BIT,
      SRC_FIVE_BIT
   } alu_src_e;

   typedef struct packed {
      alu_op_e           op;
      alu_src_e          src;
      logic [DATA_W-1:0] a;
      logic [DATA_W-1:0] b;
      logic [9:0]        lit;
      logic [3:0]        shift;
      logic              acc_sel;
      logic              periph;
      logic [4:0]        dest;
   } alu_req_s;

   typedef struct packed {
      logic carry;
      logic nibble_carry_flag;
      logic negative;
      logic signed_wrap_flag;
      logic zero;
   } flags_s;

   typedef struct packed {
      logic accumulator_a_overflow;
      logic accumulator_b_overflow;
      logic acc_a_clamped;
      logic acc_b_clamped;
   } acc_flags_s;

   localparam flags_s     FLAGS_RST     = '0;
   localparam acc_flags_s ACC_FLAGS_RST = '0;

   // peripheral operand costs one extra cycle
   localparam logic [1:0] BASE_CYCLES   = 2'h1;
   localparam logic [1:0] PERIPH_CYCLES = 2'h2;

   localparam logic [ACC_W-1:0] ACC_MAX = 40'h007fffffff;
   localparam logic [ACC_W-1:0] ACC_MIN = 40'hff80000000;

endpackage

// *** rtl/acc_unit.sv ***
`timescale 1ns/100ps
module acc_unit (
   input  wire logic [15:0] src,
   input  wire logic [3:0]  shift,
   input  wire logic [39:0] acc_in,
   output logic      [39:0] acc_out,
   output logic             ovf,
   output logic             clamped
);
   // ----------------------------------------------------------------
   // sign extend, shift, add, saturate
   // ----------------------------------------------------------------
   wire logic [39:0] ext     = {{8{src[15]}}, src, 16'h0000};
   wire logic        sh_left = shift[3];
   // a literal of -8 needs all four bits of magnitude
   wire logic [3:0]  sh_mag  = sh_left ? 4'(~shift + 4'h1) : shift;
   // negative literal shifts left, positive shifts right arithmetic
   wire logic [39:0] shifted = sh_left ? (ext << sh_mag) : 40'($signed(ext) >>> sh_mag);
   wire logic [40:0] sum     = {acc_in[39], acc_in} + {shifted[39], shifted};
   // overflow past bit 31 means guard bits are in use
   assign ovf = (sum[39:31] != {9{sum[39]}});
   wire logic        cat     = sum[40] != sum[39];
   assign clamped = cat;
   assign acc_out = !cat ? sum[39:0] : (sum[40] ? alu_pkg::ACC_MIN : alu_pkg::ACC_MAX);
endmodule

// *** rtl/alu_core.sv ***
// How it works
// RULE1: accumulator add sign-extends source, shifts by signed literal, sets overflow and clamp.
// RULE2: carry add into default working register sums file reg, that register, carry.
// RULE3: carry add with ten-bit literal updates C, nibble carry, N, wrap, Z.
// RULE4: three-operand carry add with five-bit literal writes separate destination, one cycle.
// RULE5: arithmetic shift right keeps sign bit, updates C, N, wrap, Z.
// RULE6: peripheral operands take one extra cycle.
// RULE7: conjunction leaves C, nibble carry, wrap unchanged; updates N and Z.
`timescale 1ns/100ps
module alu_core (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  req_valid,
   input  wire alu_pkg::alu_req_s     req,
   output logic                       busy,
   output logic                       res_valid,
   output logic [15:0]                result,
   output logic [4:0]                 res_dest,
   output logic                       acc_valid,
   output logic [39:0]                acc_a,
   output logic [39:0]                acc_b,
   output alu_pkg::flags_s            flags,
   output alu_pkg::acc_flags_s        acc_flags
);
   // ----------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------
   typedef enum logic {IDLE, WAIT} state_e;

   state_e                   state_q, state_d;
   alu_pkg::alu_req_s        hold_q;
   alu_pkg::flags_s          flags_q, flags_d;
   alu_pkg::acc_flags_s      accf_q, accf_d;
   logic [39:0]              acc_a_q, acc_b_q;
   logic                     res_valid_q, acc_valid_q;
   logic [15:0]              result_q, result_d;
   logic [4:0]               dest_q;

   // ----------------------------------------------------------------
   // operand selection
   // ----------------------------------------------------------------
   wire logic                go_now   = req_valid && state_q == IDLE && !req.periph;
   wire logic                go_late  = state_q == WAIT;
   wire logic                exec     = go_now || go_late;
   wire alu_pkg::alu_req_s   cur      = go_late ? hold_q : req;
   // literals are zero extended; only the register source can be negative
   wire logic [15:0]         lit_wide = {6'h00, cur.lit};
   wire logic [15:0]         lit_nar  = {11'h000, cur.lit[4:0]};
   wire logic [15:0]         opb      = cur.src == alu_pkg::SRC_TEN_BIT  ? lit_wide :
                                        cur.src == alu_pkg::SRC_FIVE_BIT ? lit_nar  :
                                        cur.b;
   // plain add ignores the stored carry; only the carry form chains it
   wire logic                cin      = cur.op == alu_pkg::OP_ADD_CARRY
                                        && flags_q.carry; // see RULE2
   wire logic [16:0]         sum      = {1'b0, cur.a} + {1'b0, opb} + {16'h0000, cin}; // see RULE4
   wire logic [4:0]          nib      = {1'b0, cur.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
   wire logic                wrap     = (cur.a[15] == opb[15]) && (sum[15] != cur.a[15]);
   wire logic [15:0]         anded    = cur.a & opb;
   wire logic [15:0]         shr      = {cur.a[15], cur.a[15:1]}; // see RULE5
   wire logic [39:0]         acc_sel  = cur.acc_sel ? acc_b_q : acc_a_q;
   wire logic [39:0]         acc_new;
   wire logic                acc_ovf, acc_clamp;

   // ----------------------------------------------------------------
   // flag candidates per operation family
   // ----------------------------------------------------------------
   wire logic                add_zero = sum[15:0] == 16'h0000;
   wire logic                and_zero = anded == 16'h0000;
   wire logic                shr_zero = shr == 16'h0000;
   wire logic                shr_out  = cur.a[0];

   // ----------------------------------------------------------------
   // accumulator path: one adder serves both, acc_sel picks which
   // ----------------------------------------------------------------
   acc_unit u_acc (
      .src     (cur.a),
      .shift   (cur.shift),
      .acc_in  (acc_sel),
      .acc_out (acc_new),
      .ovf     (acc_ovf),
      .clamped (acc_clamp)
   ); // see RULE1

   // ----------------------------------------------------------------
   // result and flag update
   // ----------------------------------------------------------------
   always_comb begin
      flags_d  = flags_q;
      accf_d   = accf_q;
      result_d = result_q;
      unique case (cur.op)
         alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY: begin
            result_d                  = sum[15:0]; // see RULE3
            flags_d.carry             = sum[16];
            flags_d.nibble_carry_flag = nib[4];
            flags_d.negative          = sum[15];
            flags_d.signed_wrap_flag  = wrap;
            flags_d.zero              = add_zero;
         end
         alu_pkg::OP_AND: begin
            result_d         = anded; // see RULE7
            flags_d.negative = anded[15];
            flags_d.zero     = and_zero;
         end
         alu_pkg::OP_SHIFT_RIGHT: begin
            result_d                 = shr; // see RULE5
            flags_d.carry            = shr_out;
            flags_d.negative         = shr[15];
            flags_d.signed_wrap_flag = 1'b0;
            flags_d.zero             = shr_zero;
         end
         alu_pkg::OP_ACC_ADD: begin
            // clamp bits stay set until reset so a past saturation is never lost
            if (cur.acc_sel) begin
               accf_d.accumulator_b_overflow = acc_ovf; // see RULE1
               accf_d.acc_b_clamped          = accf_q.acc_b_clamped | acc_clamp;
            end else begin
               accf_d.accumulator_a_overflow = acc_ovf;
               accf_d.acc_a_clamped          = accf_q.acc_a_clamped | acc_clamp;
            end
         end
         default: begin
         end
      endcase
   end

   wire logic is_acc  = cur.op == alu_pkg::OP_ACC_ADD;
   // a nop or an accumulator add gives no register write-back pulse
   wire logic is_wr   = exec && !is_acc && cur.op != alu_pkg::OP_NOP;
   wire logic acc_wr  = exec && is_acc;
   wire logic wr_a    = acc_wr && !cur.acc_sel;
   wire logic wr_b    = acc_wr && cur.acc_sel;

   // ----------------------------------------------------------------
   // sequencing: peripheral operand holds one extra cycle
   // ----------------------------------------------------------------
   // the held copy frees the request lines during the stall; a request
   // presented in that cycle is dropped, not queued
   wire logic                park     = state_q == IDLE && req_valid && req.periph;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         IDLE: begin
            if (park) begin
               state_d = WAIT; // see RULE6
            end
         end
         WAIT: begin
            state_d = IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= IDLE;
         hold_q  <= '0;
      end else begin
         state_q <= state_d;
         if (park) begin
            hold_q <= req;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_q     <= alu_pkg::FLAGS_RST;
         accf_q      <= alu_pkg::ACC_FLAGS_RST;
         result_q    <= '0;
         dest_q      <= '0;
         res_valid_q <= 1'b0;
         acc_valid_q <= 1'b0;
      end else begin
         res_valid_q <= is_wr;
         acc_valid_q <= acc_wr;
         if (exec) begin
            flags_q  <= flags_d;
            accf_q   <= accf_d;
            result_q <= result_d;
            dest_q   <= cur.dest;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_a_q <= '0;
      end else if (wr_a) begin
         acc_a_q <= acc_new;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_b_q <= '0;
      end else if (wr_b) begin
         acc_b_q <= acc_new;
      end
   end

   // ----------------------------------------------------------------
   // outputs: all straight from flops
   // ----------------------------------------------------------------
   // busy marks the stall cycle; the issuing side must not request then
   logic busy_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= park;
      end
   end

   assign busy      = busy_q;
   assign res_valid = res_valid_q;
   assign result    = result_q;
   assign res_dest  = dest_q;
   assign acc_valid = acc_valid_q;
   assign acc_a     = acc_a_q;
   assign acc_b     = acc_b_q;
   assign flags     = flags_q;
   assign acc_flags = accf_q;
endmodule

// *** tb/alu_core_chk.sv ***
`timescale 1ns/100ps
// ---
// alu core port checks
// ---
module alu_core_chk (
   input wire logic                clk,
   input wire logic                rstn,
   input wire logic                req_valid,
   input wire alu_pkg::alu_req_s   req,
   input wire logic                busy,
   input wire logic                res_valid,
   input wire logic [15:0]         result,
   input wire logic [4:0]          res_dest,
   input wire logic                acc_valid,
   input wire logic [39:0]         acc_a,
   input wire logic [39:0]         acc_b,
   input wire alu_pkg::flags_s     flags,
   input wire alu_pkg::acc_flags_s acc_flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire        tk    = req_valid && !busy && !req.periph;
   wire        sum_with_carry_instruction  = tk && req.op == alu_pkg::OP_ADD_CARRY;
   wire        accgo = tk && req.op == alu_pkg::OP_ACC_ADD;
   wire [15:0] e_reg = req.a + req.b + flags.carry;
   wire [15:0] e_l10 = req.a + req.lit + flags.carry;
   wire [15:0] e_l5  = req.a + req.lit[4:0] + flags.carry;
   wire [15:0] asr_r = {req.a[15], req.a[15:1]};
   wire        asr_c = req.a[0];
   wire [2:0]  keep  = {flags.carry, flags.nibble_carry_flag, flags.signed_wrap_flag};
   chk_sum_with_carry_instruction_reg_sum:
      assert property (sum_with_carry_instruction && req.src == alu_pkg::SRC_REG |=> res_valid && result == $past(e_reg))
      else $error("reg carry sum wrong");
   chk_sum_with_carry_instruction_ten_bit_literal:
      assert property (sum_with_carry_instruction && req.src == alu_pkg::SRC_TEN_BIT |=> result == $past(e_l10))
      else $error("ten-bit literal carry sum wrong");
   chk_sum_with_carry_instruction_five_bit_literal:
      assert property (sum_with_carry_instruction && req.src == alu_pkg::SRC_FIVE_BIT
         |=> res_valid && result == $past(e_l5) && res_dest == $past(req.dest))
      else $error("five-bit literal carry sum or dest wrong");
   chk_asr_sign:
      assert property (tk && req.op == alu_pkg::OP_SHIFT_RIGHT
         |=> result == $past(asr_r) && flags.carry == $past(asr_c) && !flags.signed_wrap_flag)
      else $error("shift result wrong");
   chk_periph_extra:
      assert property (req_valid && !busy && req.periph |=> busy && !res_valid ##1 !busy)
      else $error("peripheral timing wrong");
   chk_and_keeps:
      assert property (tk && req.op == alu_pkg::OP_AND
         |=> $stable(keep) && flags.zero == (result == 16'h0000) && flags.negative == result[15])
      else $error("conjunction flags wrong");
   chk_acc_done:
      assert property (accgo |=> acc_valid ##1 (!acc_valid || $past(accgo)))
      else $error("acc add not done in one cycle");
   chk_acc_ovf:
      assert property (acc_valid |->
         acc_flags.accumulator_a_overflow == !(&acc_a[39:31] || ~|acc_a[39:31]))
      else $error("acc overflow flag wrong");
endmodule
bind alu_core alu_core_chk u_chk (.clk, .rstn, .req_valid, .req, .busy, .res_valid, .result,
   .res_dest, .acc_valid, .acc_a, .acc_b, .flags, .acc_flags);

// *** tb/alu_core_tb.sv ***
`timescale 1ns/100ps
// ---
// alu core bench
// ---
module alu_core_tb;
   logic                clk, rstn, req_valid, busy, res_valid, acc_valid;
   alu_pkg::alu_req_s   req;
   logic [15:0]         result;
   logic [4:0]          res_dest;
   logic [39:0]         acc_a, acc_b;
   alu_pkg::flags_s     flags;
   alu_pkg::acc_flags_s acc_flags;
   int                  err_count, cmp_count;
   alu_core uut (.clk, .rstn, .req_valid, .req, .busy, .res_valid, .result, .res_dest,
      .acc_valid, .acc_a, .acc_b, .flags, .acc_flags);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic final_report();
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [39:0] e, input logic [39:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one request, then a bounded wait for its answer
   task automatic run(input alu_pkg::alu_op_e op, input alu_pkg::alu_src_e src,
                      input logic [15:0] a, input logic [15:0] b, input logic [9:0] lit,
                      input logic per);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      // b is unused by the accumulator add, so it carries pick and shift there
      req <= '{op: op, src: src, a: a, b: b, lit: lit, shift: b[3:0], acc_sel: b[4],
               periph: per, dest: 5'h15};
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      cmp("busy", {39'h0, per}, busy);
      n = 0;
      while ((res_valid | acc_valid) !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4) begin
         err_count++;
         final_report();
      end
      cmp("latency", per ? alu_pkg::PERIPH_CYCLES : alu_pkg::BASE_CYCLES, n + 1);
   endtask
   task automatic t_sum_with_carry_instruction_reg();
      run(alu_pkg::OP_ADD_CARRY, alu_pkg::SRC_REG, 16'hffff, 16'h0001, 10'h000, 1'b0);
      cmp("result", 16'h0000, result);
      cmp("flags", 5'h19, flags);
      run(alu_pkg::OP_ADD_CARRY, alu_pkg::SRC_REG, 16'h7fff, 16'h0000, 10'h000, 1'b0);
      cmp("result", 16'h8000, result);
      cmp("flags", 5'h0e, flags);
   endtask
   task automatic t_sum_with_carry_instruction_lit();
      run(alu_pkg::OP_ADD_CARRY, alu_pkg::SRC_TEN_BIT, 16'hfc01, 16'h0000, 10'h3ff, 1'b0);
      cmp("result", 16'h0000, result);
      cmp("flags", 5'h19, flags);
      run(alu_pkg::OP_ADD_CARRY, alu_pkg::SRC_FIVE_BIT, 16'hfff0, 16'h0000, 10'h3ff, 1'b0);
      cmp("result", 16'h0010, result);
      cmp("dest", 5'h15, res_dest);
      cmp("flags", 5'h18, flags);
   endtask
   task automatic t_and_asr();
      run(alu_pkg::OP_AND, alu_pkg::SRC_REG, 16'hf0f0, 16'h8f0f, 10'h000, 1'b0);
      cmp("result", 16'h8000, result);
      cmp("flags", 5'h1c, flags);
      run(alu_pkg::OP_SHIFT_RIGHT, alu_pkg::SRC_REG, 16'h0002, 16'h0000, 10'h000, 1'b0);
      cmp("result", 16'h0001, result);
      cmp("flags", 5'h08, flags);
      run(alu_pkg::OP_SHIFT_RIGHT, alu_pkg::SRC_REG, 16'h8001, 16'h0000, 10'h000, 1'b1);
      cmp("result", 16'hc000, result);
      cmp("flags", 5'h1c, flags);
   endtask
   task automatic t_acc();
      run(alu_pkg::OP_ACC_ADD, alu_pkg::SRC_REG, 16'h4000, 16'h0000, 10'h000, 1'b0);
      cmp("acc_a", 40'h0040000000, acc_a);
      run(alu_pkg::OP_ACC_ADD, alu_pkg::SRC_REG, 16'h4000, 16'h0000, 10'h000, 1'b0);
      cmp("acc_a", 40'h0080000000, acc_a);
      cmp("acc_b", 40'h0, acc_b);
      cmp("acc_flags", 4'h8, acc_flags);
      run(alu_pkg::OP_ACC_ADD, alu_pkg::SRC_REG, 16'h8000, 16'h0001, 10'h000, 1'b0);
      cmp("acc_a", 40'h0040000000, acc_a);
      cmp("acc_flags", 4'h0, acc_flags);
      run(alu_pkg::OP_ACC_ADD, alu_pkg::SRC_REG, 16'hffff, 16'h001f, 10'h000, 1'b0);
      cmp("acc_b", 40'hfffffe0000, acc_b);
      cmp("acc_a", 40'h0040000000, acc_a);
      run(alu_pkg::OP_ACC_ADD, alu_pkg::SRC_REG, 16'h0001, 16'h0018, 10'h000, 1'b0);
      cmp("acc_b", 40'h0000fe0000, acc_b);
      cmp("acc_flags", 4'h0, acc_flags);
   endtask
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_sum_with_carry_instruction_reg();
      t_sum_with_carry_instruction_lit();
      t_and_asr();
      t_acc();
      final_report();
   end
endmodule
